// File: hw/spc_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the input may change at any time relative to clk.
module spc_pin_sync
    import spc_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pin side
    input wire logic [W-1:0] pin,
    // Synchronised level
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] lvl;
    } spc_sync_st_t;

    spc_sync_st_t st_r;
    spc_sync_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ff1 = pin;
        st_nxt.ff2 = st_r.ff1;
        st_nxt.ff3 = st_r.ff2;
        // A change counts only once the last two stages agree
        for (int i = 0; i < W; i++) begin
            if (st_r.ff2[i] == st_r.ff3[i]) begin
                st_nxt.lvl[i] = st_r.ff3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{ff1: RST_VAL, ff2: RST_VAL, ff3: RST_VAL, lvl: RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;
endmodule : spc_pin_sync

// File: hw/spc_pkg.sv
// Constants, register map and carrier types of the six-channel PWM control.
// Assumes one 25 MHz clock and an Avalon-MM slave with byte addressing.
// Contract
// - Written period/duty load at period match
// - Immediate-update bit applies new values at once
// - Updates need three clocks before taking effect
// - Up/down mode doubles effective period and duty
// - Sync enable routes blanking input into PWM
// - Blanking low forces outputs idle, counter reset
// - Blanking high restarts counter and outputs
// - Halt idles outputs, counter zero, settings kept
// - Run control off freezes output pin levels
// - Drive-all-from-A: every output from channel A
// - Drive-all-from-A applies per-channel polarity bits
// - Six-channel mode: own duty, complementary pairs
// - Update-all: A duty write also updates B, C
// - Port release lets stopped pins follow port control
// - Disabled pins in drive modes follow port control
// - Ten-bit period and duty from extension bits
// - Duty equal period or zero gives constant level
package spc_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_PERIOD_LOW = 8'hb5;
    localparam logic [7:0] IDX_DUTY_A = 8'hb6;
    localparam logic [7:0] IDX_MAIN_CTRL = 8'hb7;
    localparam logic [7:0] IDX_DUTY_B = 8'hba;
    localparam logic [7:0] IDX_DUTY_C = 8'hbb;
    localparam logic [7:0] IDX_EXTENSION = 8'hbc;
    localparam logic [7:0] IDX_DRIVE = 8'hbd;
    localparam logic [7:0] IDX_POL_PORT = 8'hbe;
    localparam logic [7:0] IDX_RUN_CTRL = 8'hc6;
    localparam logic [7:0] IDX_PORT_DIR = 8'hc7;
    localparam logic [7:0] IDX_STATUS = 8'hc8;
    localparam logic [7:0] IDX_COUNT_LOW = 8'hc9;

    // Reset values
    localparam logic [7:0] RST_PERIOD_LOW = 8'hff;
    localparam logic [7:0] RST_DUTY = 8'h7f;
    localparam logic [7:0] RST_CTRL = 8'h00;
    // Bit 1 of the polarity/port register is reserved and reads zero
    localparam logic [7:0] POL_PORT_MASK = 8'hfd;

    // Main control fields
    localparam int MC_PINS_EN = 7;
    localparam int MC_EXT_SYNC = 6;
    localparam int MC_UPDOWN = 5;
    localparam int MC_HALT = 4;
    localparam int MC_IMM = 3;
    localparam int MC_UPD_ALL = 2;
    // Drive register fields; pin enables sit in bits 5..0
    localparam int DR_ALL_A = 7;
    localparam int DR_SIX = 6;
    // Polarity/port fields
    localparam int PP_POL_A = 6;
    localparam int PP_POL_B = 5;
    localparam int PP_POL_C = 4;
    localparam int PP_RELEASE = 3;
    // Extension register: period [1:0], duty A [7:6], B [5:4], C [3:2]
    localparam int EX_PER = 0;
    localparam int EX_A = 6;
    localparam int EX_B = 4;
    localparam int EX_C = 2;

    // Clocks between a write and the point where it may take effect
    localparam int SYNC_CYCLES = 3;
    localparam int PIN_SYNC_STAGES = 3;

    // Pending masks: bit 0 period, 1..3 duty A..C
    localparam int PM_PER = 0;
    localparam int PM_A = 1;
    localparam int PM_B = 2;
    localparam int PM_C = 3;

    typedef struct packed {
        logic [9:0] period;
        logic [9:0] duty_a;
        logic [9:0] duty_b;
        logic [9:0] duty_c;
    } spc_active_t;

    // Pin order: 5 A, 4 A inverted, 3 B, 2 B inverted, 1 C, 0 C inverted
    typedef struct packed {
        logic [5:0] level;
        logic [5:0] oe_b;
    } spc_pins_t;
endpackage : spc_pkg

// File: hw/spc_pwm_ctrl.sv
// Six-channel PWM control: register file, counter, update path, pin drive.
// Assumes a single clk, an Avalon-MM master and an external power stage.
//
// The Avalon-MM register port was decided locally.
module spc_pwm_ctrl
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Blanking pin, asynchronous, active low
    input wire logic blanking_input_n,
    // PWM pins: level, and output enable low while driven
    output logic [5:0] pwm_out,
    output logic [5:0] pwm_oe_b
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] main_ctrl;
        logic [7:0] drive;
        logic [7:0] pol_port;
        logic [7:0] run_ctrl;
        logic [7:0] port_dir;
        logic [7:0] per_low;
        logic [7:0] ext;
        logic [7:0] dr_a;
        logic [7:0] dr_b;
        logic [7:0] dr_c;
        logic [SYNC_CYCLES-1:0][3:0] upd_pipe;
        logic [3:0] pend;
        spc_active_t act;
        logic [9:0] cnt;
        logic down;
        spc_pins_t pins;
    } spc_st_t;

    spc_st_t st_r;
    spc_st_t st_nxt;
    logic blank_lvl;

    spc_pin_sync #(.W(1), .RST_VAL(1'b1)) u_blank_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin(blanking_input_n),
        .level(blank_lvl)
    );

    logic [7:0] idx;
    logic wr_hit;
    logic [7:0] wbyte;
    logic halt;
    logic blanked;
    logic run;
    logic stopped;
    logic match;
    logic [3:0] arrive;
    logic [3:0] load;
    logic [9:0] per;
    logic [2:0] pol;
    logic [2:0] wav;
    logic [5:0] true_lvl;
    logic [5:0] idle_lvl;
    logic [5:0] pin_en;
    logic [7:0] rd_byte;

    assign idx = avs_address[9:2];
    assign wbyte = avs_writedata[7:0];
    assign wr_hit = avs_write && !st_r.ack && avs_byteenable[0];
    // One wait state, then the answer edge
    assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
    assign avs_readdata = st_r.rdata;
    assign pwm_out = st_r.pins.level;
    assign pwm_oe_b = st_r.pins.oe_b;

    assign halt = st_r.main_ctrl[MC_HALT];
    // Blanking acts only once the pin synchroniser has agreed
    assign blanked = st_r.main_ctrl[MC_EXT_SYNC] && !blank_lvl;
    assign run = st_r.run_ctrl[0];
    assign stopped = halt || blanked || !run;
    assign per = st_r.act.period;
    assign pol = {st_r.pol_port[PP_POL_A], st_r.pol_port[PP_POL_B], st_r.pol_port[PP_POL_C]};

    // Period match: end of an up count, or bottom of the down slope
    always_comb begin
        if (st_r.main_ctrl[MC_UPDOWN]) begin
            // A zero period must still match, or pending values never load
            match = (per == 10'h000) || (st_r.down && (st_r.cnt <= 10'h001));
        end else begin
            match = (per == 10'h000) || (st_r.cnt >= per - 10'h001);
        end
    end

    // Channel waveforms before polarity; zero duty never high, full duty always
    always_comb begin
        wav[2] = st_r.down ? (st_r.cnt <= st_r.act.duty_a) : (st_r.cnt < st_r.act.duty_a);
        wav[1] = st_r.down ? (st_r.cnt <= st_r.act.duty_b) : (st_r.cnt < st_r.act.duty_b);
        wav[0] = st_r.down ? (st_r.cnt <= st_r.act.duty_c) : (st_r.cnt < st_r.act.duty_c);
        if (st_r.act.duty_a == 10'h000) begin
            wav[2] = 1'b0;
        end
        if (st_r.act.duty_b == 10'h000) begin
            wav[1] = 1'b0;
        end
        if (st_r.act.duty_c == 10'h000) begin
            wav[0] = 1'b0;
        end
        if (st_r.drive[DR_ALL_A]) begin
            wav[1] = wav[2];
            wav[0] = wav[2];
        end
    end

    // Pair levels with polarity, and idle levels
    generate
        for (genvar ch = 0; ch < 3; ch++) begin : g_pair
            // Polarity 1 gives active-high; the partner is the opposite phase
            assign true_lvl[2*ch+1] = pol[ch] ? wav[ch] : !wav[ch];
            assign true_lvl[2*ch] = !true_lvl[2*ch+1];
            // Idle is the inactive phase, the same for halt and blanking
            assign idle_lvl[2*ch+1] = !pol[ch];
            assign idle_lvl[2*ch] = pol[ch];
        end
    endgenerate

    // Neither force mode: all six pins run; force modes: per-pin enables
    assign pin_en = (st_r.drive[DR_ALL_A] || st_r.drive[DR_SIX]) ? st_r.drive[5:0] : 6'h3f;

    // Write events leave the update pipe by kind; load at match, or on arrival with immediate update
    always_comb begin
        arrive = st_r.upd_pipe[SYNC_CYCLES-1];
        if (st_r.main_ctrl[MC_IMM]) begin
            load = match ? (st_r.pend | arrive) : arrive;
        end else begin
            load = match ? (st_r.pend | arrive) : 4'h0;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            IDX_PERIOD_LOW: rd_byte = st_r.per_low;
            IDX_DUTY_A: rd_byte = st_r.dr_a;
            IDX_MAIN_CTRL: rd_byte = st_r.main_ctrl;
            IDX_DUTY_B: rd_byte = st_r.dr_b;
            IDX_DUTY_C: rd_byte = st_r.dr_c;
            IDX_EXTENSION: rd_byte = st_r.ext;
            IDX_DRIVE: rd_byte = st_r.drive;
            IDX_POL_PORT: rd_byte = st_r.pol_port & POL_PORT_MASK;
            // Run control reads back count high bits, blanking and direction
            IDX_RUN_CTRL: rd_byte = {2'h0, st_r.cnt[9:8], 1'b0, ~blank_lvl, st_r.down,
                                    st_r.run_ctrl[0]};
            IDX_PORT_DIR: rd_byte = {2'h0, st_r.port_dir[5:0]};
            IDX_STATUS: rd_byte = {stopped, blanked, st_r.pins.level};
            IDX_COUNT_LOW: rd_byte = st_r.cnt[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        logic [3:0] wr_kind;
        wr_kind = 4'h0;
        st_nxt = st_r;

        // Bus answer: one wait state, then a one-cycle acknowledge
        st_nxt.ack = (avs_read || avs_write) && !st_r.ack;
        if (avs_read && !st_r.ack) begin
            st_nxt.rdata = {24'h000000, rd_byte};
        end

        if (wr_hit) begin
            case (idx)
                IDX_PERIOD_LOW: begin
                    st_nxt.per_low = wbyte;
                    wr_kind[PM_PER] = 1'b1;
                end
                IDX_DUTY_A: begin
                    st_nxt.dr_a = wbyte;
                    wr_kind[PM_A] = 1'b1;
                    if (st_r.main_ctrl[MC_UPD_ALL]) begin
                        wr_kind[PM_B] = 1'b1;
                        wr_kind[PM_C] = 1'b1;
                    end
                end
                IDX_MAIN_CTRL: st_nxt.main_ctrl = wbyte;
                IDX_DUTY_B: begin
                    st_nxt.dr_b = wbyte;
                    // With update-all, B waits for the next A write
                    wr_kind[PM_B] = !st_r.main_ctrl[MC_UPD_ALL];
                end
                IDX_DUTY_C: begin
                    st_nxt.dr_c = wbyte;
                    wr_kind[PM_C] = !st_r.main_ctrl[MC_UPD_ALL];
                end
                IDX_EXTENSION: begin
                    st_nxt.ext = wbyte;
                    wr_kind = st_r.main_ctrl[MC_UPD_ALL] ? 4'h3 : 4'hf;
                end
                IDX_DRIVE: st_nxt.drive = wbyte;
                IDX_POL_PORT: st_nxt.pol_port = wbyte & POL_PORT_MASK;
                IDX_RUN_CTRL: st_nxt.run_ctrl = {7'h00, wbyte[0]};
                IDX_PORT_DIR: st_nxt.port_dir = {2'h0, wbyte[5:0]};
                // Unmapped indices take the write and keep nothing
                default: st_nxt.run_ctrl = st_r.run_ctrl;
            endcase
        end

        // Three-clock transfer stage ahead of the active registers
        st_nxt.upd_pipe[0] = wr_kind;
        for (int i = 1; i < SYNC_CYCLES; i++) begin
            st_nxt.upd_pipe[i] = st_r.upd_pipe[i-1];
        end
        // A late arrival on the load cycle is still kept
        st_nxt.pend = (st_r.pend | arrive) & ~load;

        // Ten-bit values formed from extension bits and low bytes
        if (load[PM_PER]) begin
            st_nxt.act.period = {st_r.ext[EX_PER+1:EX_PER], st_r.per_low};
        end
        if (load[PM_A]) begin
            st_nxt.act.duty_a = {st_r.ext[EX_A+1:EX_A], st_r.dr_a};
        end
        if (load[PM_B]) begin
            st_nxt.act.duty_b = {st_r.ext[EX_B+1:EX_B], st_r.dr_b};
        end
        if (load[PM_C]) begin
            st_nxt.act.duty_c = {st_r.ext[EX_C+1:EX_C], st_r.dr_c};
        end

        // Counter
        // Halt and blanking clear it, so a restart opens a fresh period
        if (halt || blanked) begin
            st_nxt.cnt = 10'h000;
            st_nxt.down = 1'b0;
        end else if (!run) begin
            st_nxt.cnt = st_r.cnt;
        end else if (st_r.main_ctrl[MC_UPDOWN]) begin
            // Up 0..P-1, down P..1: twice the programmed period
            if (per == 10'h000) begin
                st_nxt.cnt = 10'h000;
                st_nxt.down = 1'b0;
            end else if (!st_r.down) begin
                st_nxt.cnt = st_r.cnt + 10'h001;
                st_nxt.down = (st_r.cnt >= per - 10'h001);
            end else if (match) begin
                st_nxt.cnt = 10'h000;
                st_nxt.down = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt - 10'h001;
            end
        end else begin
            st_nxt.down = 1'b0;
            st_nxt.cnt = match ? 10'h000 : st_r.cnt + 10'h001;
        end

        // Pin drive
        // Released pins hold level low inside; the port decides the pin
        for (int p = 0; p < 6; p++) begin
            if (!st_r.main_ctrl[MC_PINS_EN]) begin
                st_nxt.pins.level[p] = 1'b0;
                st_nxt.pins.oe_b[p] = !st_r.port_dir[p];
            end else if (!pin_en[p]) begin
                st_nxt.pins.level[p] = 1'b0;
                st_nxt.pins.oe_b[p] = !st_r.port_dir[p];
            end else if (stopped && st_r.pol_port[PP_RELEASE]) begin
                st_nxt.pins.level[p] = 1'b0;
                st_nxt.pins.oe_b[p] = !st_r.port_dir[p];
            end else if (halt || blanked) begin
                st_nxt.pins.level[p] = idle_lvl[p];
                st_nxt.pins.oe_b[p] = 1'b0;
            end else if (!run) begin
                st_nxt.pins.level[p] = st_r.pins.level[p];
                st_nxt.pins.oe_b[p] = 1'b0;
            end else begin
                st_nxt.pins.level[p] = true_lvl[p];
                st_nxt.pins.oe_b[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.per_low <= RST_PERIOD_LOW;
            st_r.dr_a <= RST_DUTY;
            st_r.dr_b <= RST_DUTY;
            st_r.dr_c <= RST_DUTY;
            // Active values start equal to the register reset values
            st_r.act.period <= {2'h0, RST_PERIOD_LOW};
            st_r.act.duty_a <= {2'h0, RST_DUTY};
            st_r.act.duty_b <= {2'h0, RST_DUTY};
            st_r.act.duty_c <= {2'h0, RST_DUTY};
            st_r.pins.oe_b <= 6'h3f;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : spc_pwm_ctrl

// File: testbench/spc_power_stage.sv
// Power stage model: gate drivers on the six PWM pins, high-time meter.
// Assumes pins register on clk; released pins are pulled low at the gate.
module spc_power_stage
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Gate drive from the PWM pins
    input wire spc_pins_t pins,
    // Measurement window
    input wire logic clr,
    input wire logic win,
    // Cycles seen high per pin inside the window
    output logic [5:0][8:0] hi
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] gate;
    // Released pin floats, so the driver's pull-down decides
    assign gate = pins.level & ~pins.oe_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hi <= '0;
        end else if (clr) begin
            hi <= '0;
        end else if (win) begin
            for (int i = 0; i < 6; i++) begin
                hi[i] <= hi[i] + 9'(gate[i]);
            end
        end
    end
endmodule : spc_power_stage

// File: testbench/spc_pwm_ctrl_monitor.sv
// Checker on the ports of the PWM control, shadowing written registers.
// Assumes the bus master holds each request until waitrequest is low.
module spc_pwm_ctrl_monitor
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins
    input wire logic blanking_input_n,
    input wire logic [5:0] pwm_out,
    input wire logic [5:0] pwm_oe_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] main_r, drv_r, pol_r, dir_r, run_r;
    logic [3:0] quiet_r, blank_r;
    logic acc, a_on;
    logic [7:0] idx;
    assign idx = avs_address[9:2];
    assign acc = avs_write && !avs_waitrequest && avs_byteenable[0];
    // Settle margin after any write, since shadows trail the design by one clock
    assign a_on = main_r[MC_PINS_EN] && drv_r[5] && drv_r[4] && run_r[0]
        && !pol_r[PP_RELEASE] && quiet_r > 4'h3;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            main_r <= 8'h00;
            drv_r <= 8'h00;
            pol_r <= 8'h00;
            dir_r <= 8'h00;
            run_r <= 8'h00;
            quiet_r <= 4'h0;
            blank_r <= 4'h0;
        end else begin
            if (acc && idx == IDX_MAIN_CTRL) main_r <= avs_writedata[7:0];
            if (acc && idx == IDX_DRIVE) drv_r <= avs_writedata[7:0];
            if (acc && idx == IDX_POL_PORT) pol_r <= avs_writedata[7:0];
            if (acc && idx == IDX_PORT_DIR) dir_r <= avs_writedata[7:0];
            if (acc && idx == IDX_RUN_CTRL) run_r <= avs_writedata[7:0];
            quiet_r <= acc ? 4'h0 : (quiet_r == 4'hf ? quiet_r : quiet_r + 4'h1);
            blank_r <= blanking_input_n ? 4'h0 : (blank_r == 4'hf ? blank_r : blank_r + 4'h1);
        end
    end
    chk_wait_one: assert property (@(posedge clk) disable iff (!rst_b)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("second wait state");
    chk_wait_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait while idle");
    chk_rd_upper: assert property (@(posedge clk) disable iff (!rst_b)
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read upper bits set");
    chk_rd_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata)) else $error("read data moved");
    chk_halt_idle: assert property (@(posedge clk) disable iff (!rst_b)
        a_on && main_r[MC_HALT] |-> pwm_out[5:4] == {!pol_r[PP_POL_A], pol_r[PP_POL_A]})
        else $error("halt level wrong");
    chk_blank_idle: assert property (@(posedge clk) disable iff (!rst_b)
        a_on && main_r[MC_EXT_SYNC] && blank_r > 4'h6
        |-> pwm_out[5:4] == {!pol_r[PP_POL_A], pol_r[PP_POL_A]}) else $error("blank level wrong");
    chk_six_pair: assert property (@(posedge clk) disable iff (!rst_b)
        a_on && drv_r[DR_SIX] && !drv_r[DR_ALL_A] |-> pwm_out[5] != pwm_out[4])
        else $error("pair not complementary");
    chk_all_a_pol: assert property (@(posedge clk) disable iff (!rst_b)
        a_on && drv_r[DR_ALL_A] && drv_r[3] && pol_r[PP_POL_A] != pol_r[PP_POL_B]
        |-> pwm_out[3] != pwm_out[5]) else $error("polarity B ignored");
    chk_oe_off: assert property (@(posedge clk) disable iff (!rst_b)
        !main_r[MC_PINS_EN] && quiet_r > 4'h1 |-> pwm_oe_b == ~dir_r[5:0])
        else $error("released pin direction wrong");
endmodule : spc_pwm_ctrl_monitor

bind spc_pwm_ctrl spc_pwm_ctrl_monitor spc_pwm_ctrl_monitor_inst (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .blanking_input_n(blanking_input_n), .pwm_out(pwm_out), .pwm_oe_b(pwm_oe_b));

// File: testbench/spc_pwm_ctrl_tb.sv
// Self-checking bench of the PWM control with a power stage model.
// Assumes one 25 MHz clock; byteenable is tied to all lanes.
module spc_pwm_ctrl_tb
    import spc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, blanking_input_n = 1'b1;
    logic [9:0] avs_address = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    logic avs_waitrequest, clr = 1'b0, win = 1'b0;
    logic [5:0] pwm_out, pwm_oe_b, p;
    logic [5:0][8:0] hi;
    int n_errors = 0, cmp_count = 0;
    always #20 clk = ~clk;
    spc_pwm_ctrl spc_pwm_ctrl_inst (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .blanking_input_n(blanking_input_n),
        .pwm_out(pwm_out), .pwm_oe_b(pwm_oe_b));
    spc_power_stage spc_power_stage_inst (.clk(clk), .rst_b(rst_b),
        .pins({pwm_out, pwm_oe_b}), .clr(clr), .win(win), .hi(hi));
    task automatic test_done;
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            $display("[FAIL] %0t bus request never answered", $time);
        end
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr
    task automatic rdx(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        cmp(rd, exp);
    endtask : rdx
    // High time per pin over n clocks, measured by the power stage
    task automatic meas(input int n);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        win <= 1'b1;
        repeat (n) @(posedge clk);
        win <= 1'b0;
        @(posedge clk);
    endtask : meas
    task automatic t_regs;
        rdx(IDX_PERIOD_LOW, 32'hff);
        rdx(IDX_DUTY_A, 32'h7f);
        rdx(IDX_MAIN_CTRL, 32'h00);
        rdx(IDX_DRIVE, 32'h00);
        rdx(IDX_POL_PORT, 32'h00);
        rdx(8'h10, 32'h00);
        wr(IDX_POL_PORT, 8'hff);
        rdx(IDX_POL_PORT, 32'hfd);
    endtask : t_regs
    task automatic t_six;
        wr(IDX_PERIOD_LOW, 8'h0a);
        wr(IDX_DUTY_A, 8'h04);
        wr(IDX_DUTY_B, 8'h00);
        wr(IDX_DUTY_C, 8'h0a);
        wr(IDX_POL_PORT, 8'h70);
        wr(IDX_DRIVE, 8'h7f);
        wr(IDX_MAIN_CTRL, 8'h80);
        wr(IDX_RUN_CTRL, 8'h01);
        repeat (300) @(posedge clk);
        meas(10);
        cmp({hi[5], hi[4], hi[3], hi[1]}, {9'd4, 9'd6, 9'd0, 9'd10});
        wr(IDX_MAIN_CTRL, 8'ha0);
        repeat (30) @(posedge clk);
        meas(20);
        cmp({hi[5], hi[3], hi[1]}, {9'd8, 9'd0, 9'd20});
    endtask : t_six
    task automatic t_imm;
        wr(IDX_MAIN_CTRL, 8'h80);
        wr(IDX_PERIOD_LOW, 8'hc8);
        wr(IDX_DUTY_A, 8'h64);
        repeat (30) @(posedge clk);
        wr(IDX_MAIN_CTRL, 8'h88);
        wr(IDX_DUTY_A, 8'h14);
        repeat (6) @(posedge clk);
        meas(200);
        cmp(hi[5], 9'd20);
        wr(IDX_MAIN_CTRL, 8'h80);
    endtask : t_imm
    task automatic t_halt;
        wr(IDX_MAIN_CTRL, 8'h90);
        repeat (4) @(posedge clk);
        cmp(pwm_out[5:4], 2'b01);
        rdx(IDX_COUNT_LOW, 32'h0);
        rdx(IDX_DUTY_A, 32'h14);
        wr(IDX_MAIN_CTRL, 8'h80);
        meas(200);
        cmp(hi[5], 9'd20);
    endtask : t_halt
    task automatic t_blank;
        meas(1);
        blanking_input_n <= 1'b0;
        meas(200);
        cmp(hi[5], 9'd20);
        blanking_input_n <= 1'b1;
        wr(IDX_MAIN_CTRL, 8'hc0);
        blanking_input_n <= 1'b0;
        repeat (8) @(posedge clk);
        cmp(pwm_out[5:4], 2'b01);
        rdx(IDX_COUNT_LOW, 32'h0);
        blanking_input_n <= 1'b1;
        repeat (210) @(posedge clk);
        meas(200);
        cmp(hi[5], 9'd20);
    endtask : t_blank
    task automatic t_stop;
        wr(IDX_RUN_CTRL, 8'h00);
        p = pwm_out;
        repeat (50) @(posedge clk);
        cmp(pwm_out, p);
        wr(IDX_POL_PORT, 8'h78);
        repeat (3) @(posedge clk);
        cmp(pwm_oe_b, 6'h3f);
        wr(IDX_POL_PORT, 8'h50);
        wr(IDX_RUN_CTRL, 8'h01);
        wr(IDX_DRIVE, 8'hbf);
        for (int i = 0; i < 200; i++) begin
            @(negedge clk);
            cmp(pwm_out[3:1], {~pwm_out[5], pwm_out[5], pwm_out[5]});
        end
        wr(IDX_DRIVE, 8'h78);
        wr(IDX_PORT_DIR, 8'h01);
        repeat (3) @(posedge clk);
        cmp(pwm_oe_b, 6'b000110);
    endtask : t_stop
    // Update-all with immediate update; extension bits widen period and A
    task automatic t_update_all_duties;
        wr(IDX_DRIVE, 8'h7f);
        wr(IDX_POL_PORT, 8'h70);
        wr(IDX_MAIN_CTRL, 8'h8c);
        wr(IDX_DUTY_B, 8'h28);
        wr(IDX_EXTENSION, 8'h41);
        wr(IDX_DUTY_A, 8'h14);
        repeat (6) @(posedge clk);
        meas(456);
        cmp({hi[5], hi[3], hi[1]}, {9'd276, 9'd40, 9'd10});
    endtask : t_update_all_duties
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_six();
        t_imm();
        t_halt();
        t_blank();
        t_stop();
        t_update_all_duties();
        test_done();
    end
endmodule : spc_pwm_ctrl_tb
